// [rtl/adc_regs.svh]
/*
  Constants of the converter's digital side: bus codes, configuration
  byte layout and defaults, and conversion timing.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// ==========================================================================
// Bus addresses and codes
`define DEV_ADDR_A 7'h48
`define DEV_ADDR_B 7'h49
`define GC_ADDR 8'h00
`define GC_RESET_CODE 8'h06
`define GC_OTHER_CODE 8'h04
`define HS_CODE 5'h01
`define FILL_BYTE 8'hff

// ==========================================================================
// Configuration byte
`define CFG_BUSY_BIT 7
`define CFG_SINGLE_BIT 4
`define CFG_GAIN_LSB 0
`define CFG_DEFAULT 8'h80

// ==========================================================================
// Result range and timing
`define SAT_MAX 2047
`define SAT_MIN (-2048)
`define SYS_CLK_HZ 200000000
`define OSC_HZ 275000
`define CONV_SPS 128
`define OSC_DIV (`SYS_CLK_HZ / `OSC_HZ)
`define CONV_TICKS_DEF (`OSC_HZ / `CONV_SPS)

`endif

// [rtl/adc_pkg.sv]
/*
  Types shared by the converter's digital side.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package adc_pkg;

  typedef struct packed {
    logic start_busy_flag;
    logic [1:0] rsv_hi;
    logic single_shot_select;
    logic [1:0] rsv_lo;
    logic [1:0] gain_setting;
  } cfg_t;

  typedef struct packed {
    logic [15:0] result;
    cfg_t cfg;
  } status_word_t;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_RUN = 1'b1
  } conv_state_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    RX_BYTE = 3'b001,
    ACK_OUT = 3'b010,
    TX_BYTE = 3'b011,
    ACK_IN = 3'b100,
    SKIP = 3'b101
  } bus_state_t;

endpackage

`default_nettype wire

// [rtl/pin_sync.sv]
/*
  Three-stage synchroniser with agreement filter, one per bit.
  Assumes inputs are asynchronous to clk; output moves only when the
  second and third stages agree, so a one-cycle glitch is dropped.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] ff1_q;
  logic [WIDTH-1:0] ff2_q;
  logic [WIDTH-1:0] ff3_q;
  logic [WIDTH-1:0] q_q;
  wire logic [WIDTH-1:0] agree = ~(ff2_q ^ ff3_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1_q <= RST_VAL;
      ff2_q <= RST_VAL;
      ff3_q <= RST_VAL;
      q_q <= RST_VAL;
    end else begin
      ff1_q <= d;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      q_q <= (ff3_q & agree) | (q_q & ~agree);
    end
  end

  assign q = q_q;

endmodule

`default_nettype wire

// [rtl/conv_core.sv]
/*
  Conversion sequencer: oscillator tick, continuous and single-shot
  sequencing, result scaling and saturation, configuration storage.
  Assumes cfg_wr and gc_reset are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"

module conv_core import adc_pkg::*; #(
  parameter int unsigned CONV_TICKS = `CONV_TICKS_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration and commands
  input wire logic cfg_wr,
  input wire cfg_t cfg_wr_data,
  input wire logic gc_reset,
  // Analog side
  input wire logic signed [15:0] analog_code,
  output logic analog_pwr_en,
  output logic [1:0] gain_setting,
  // Status
  output logic [15:0] result,
  output cfg_t cfg_rd
);

  localparam logic [9:0] DIV_LAST = 10'(`OSC_DIV - 1);
  localparam logic [11:0] CONV_LAST = 12'(CONV_TICKS - 1);
  localparam cfg_t CFG_RST = cfg_t'(`CFG_DEFAULT);
  localparam logic signed [18:0] SAT_HI = 19'(`SAT_MAX);
  localparam logic signed [18:0] SAT_LO = 19'(`SAT_MIN);

  conv_state_t state_q;
  logic [9:0] div_q;
  logic [11:0] tick_cnt_q;
  logic [15:0] out_q;
  logic single_q;
  logic [1:0] gain_q;
  logic pwr_q;

  // ==========================================================================
  // Decode
  // The oscillator tick is the only timebase for conversions
  wire logic tick = (div_q == DIV_LAST);
  wire logic conv_done = (state_q == CONV_RUN) && tick &&
    (tick_cnt_q == CONV_LAST);
  wire logic wr_single = cfg_wr ? cfg_wr_data.single_shot_select
    : single_q;
  // A start written during a running conversion is simply not seen
  wire logic start = (state_q == CONV_IDLE) &&
    (!wr_single || (cfg_wr && cfg_wr_data.start_busy_flag));
  wire logic signed [18:0] wide = {{3{analog_code[15]}}, analog_code};
  wire logic signed [18:0] scaled = wide <<< gain_q;
  wire logic [15:0] sat = (scaled > SAT_HI) ? 16'h07ff :
    (scaled < SAT_LO) ? 16'hf800 : scaled[15:0];

  // ==========================================================================
  // Sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 10'h000;
    end else begin
      div_q <= tick ? 10'h000 : div_q + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CONV_IDLE;
      tick_cnt_q <= 12'h000;
      out_q <= 16'h0000;
      single_q <= CFG_RST.single_shot_select;
      gain_q <= CFG_RST.gain_setting;
      pwr_q <= 1'b0;
    end else if (gc_reset) begin
      state_q <= CONV_IDLE;
      tick_cnt_q <= 12'h000;
      out_q <= 16'h0000;
      single_q <= CFG_RST.single_shot_select;
      gain_q <= CFG_RST.gain_setting;
      pwr_q <= 1'b0;
    end else begin
      if (cfg_wr) begin
        single_q <= cfg_wr_data.single_shot_select;
        gain_q <= cfg_wr_data.gain_setting;
      end
      unique case (state_q)
        CONV_IDLE: begin
          if (start) begin
            state_q <= CONV_RUN;
            tick_cnt_q <= 12'h000;
            pwr_q <= 1'b1;
          end
        end
        CONV_RUN: begin
          if (conv_done) begin
            out_q <= sat;
            tick_cnt_q <= 12'h000;
            if (wr_single) begin
              state_q <= CONV_IDLE;
              pwr_q <= 1'b0;
            end
          end else if (tick) begin
            tick_cnt_q <= tick_cnt_q + 12'h001;
          end
        end
      endcase
    end
  end

  assign analog_pwr_en = pwr_q;
  assign gain_setting = gain_q;
  assign result = out_q;
  // Busy reads 1 throughout continuous mode
  assign cfg_rd = '{start_busy_flag: !single_q || (state_q == CONV_RUN),
    rsv_hi: 2'h0, single_shot_select: single_q, rsv_lo: 2'h0,
    gain_setting: gain_q};

  // ==========================================================================
  // Checks
  property p_cont_restart;
    @(posedge clk) disable iff (!rst_n)
    conv_done && !wr_single && !gc_reset |=> state_q == CONV_RUN
      && tick_cnt_q == 12'h000;
  endproperty
  a_cont_restart: assert property (p_cont_restart)
    else $error("continuous mode did not restart");

  property p_single_end;
    @(posedge clk) disable iff (!rst_n)
    conv_done && wr_single && !gc_reset |=> state_q == CONV_IDLE
      && !cfg_rd.start_busy_flag && !analog_pwr_en;
  endproperty
  a_single_end: assert property (p_single_end)
    else $error("single-shot end not idle");

  property p_hold_idle;
    @(posedge clk) disable iff (!rst_n)
    state_q == CONV_IDLE && single_q && !cfg_wr |=>
      state_q == CONV_IDLE && !analog_pwr_en;
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("single-shot left idle without start");

  property p_no_abort;
    @(posedge clk) disable iff (!rst_n)
    state_q == CONV_RUN && !conv_done && !gc_reset |=>
      state_q == CONV_RUN && tick_cnt_q >= $past(tick_cnt_q);
  endproperty
  a_no_abort: assert property (p_no_abort)
    else $error("running conversion disturbed");

  property p_gc_clear;
    @(posedge clk) disable iff (!rst_n)
    gc_reset |=> out_q == 16'h0000 && state_q == CONV_IDLE
      && gain_q == 2'h0 && !single_q;
  endproperty
  a_gc_clear: assert property (p_gc_clear)
    else $error("general-call reset incomplete");

  property p_sat;
    @(posedge clk) disable iff (!rst_n)
    conv_done |=> out_q[15:11] == 5'h00 || out_q[15:11] == 5'h1f;
  endproperty
  a_sat: assert property (p_sat)
    else $error("result out of 12-bit range");

endmodule

`default_nettype wire

// [rtl/adc_i2c_slave.sv]
/*
  Digital side of a 12-bit converter: two-wire serial slave on the link
  clock, conversion sequencer on sys_clk, crossings between them.
  Assumes link_clk runs freely at several times the bus clock rate and
  that the analog code is valid on sys_clk whenever power is enabled.
*/
// Summary of operation
// - results are two's complement, saturated -2048..2047, scaled by gain.
// - conversion timing comes only from the internal oscillator tick.
// - continuous mode stores each result and restarts immediately.
// - in continuous mode the start/busy flag always reads 1.
// - single-shot waits powered down until start flag written as 1.
// - single-shot end stores result, clears flag, powers down.
// - a start written during a running conversion is ignored.
// - switching to single-shot finishes current conversion, then idles.
// - reset loads every configuration field with its default.
// - slave only; the clock line is an input, never driven.
// - lines are only pulled low or released.
// - data changes while clock low; one bit per clock high; bytes of 8.
// - start and stop are detected at any point.
// - device's own address is 48h or 49h, fixed by ADDR_SEL.
// - device pulls data low in the ack slot of each accepted byte.
// - repeated start opens new address phase; stop returns to idle.
// - general call 00h then 06h is acked and resets the device.
// - that reset aborts conversion, zeroes output, restores config.
// - general-call address always acked; data only when 04h or 06h.
// - reads give result high, result low, config, then FFh.
// - first written byte loads config; later bytes not acked.
// - single-shot select 1 means single-shot; reset value continuous.
// - high-speed master code is acked; mode ends at next stop.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"

module adc_i2c_slave import adc_pkg::*; #(
  parameter logic ADDR_SEL = 1'b0,
  parameter int unsigned CONV_TICKS = `CONV_TICKS_DEF
) (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic link_clk,
  // Serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Analog front end
  input wire logic signed [15:0] analog_code,
  output logic analog_pwr_en,
  output logic [1:0] gain_setting,
  output logic high_speed_bus_mode
);

  localparam logic [6:0] DEV_ADDR = ADDR_SEL ? `DEV_ADDR_B
    : `DEV_ADDR_A;

  // ==========================================================================
  // Conversion side (sys_clk)
  logic [2:0] sys_s;
  logic [2:0] sys_p_q;
  logic pub_req_q;
  status_word_t pub_q;
  logic [15:0] result;
  cfg_t cfg_rd;
  logic ack_q;
  logic wr_tgl_q;
  logic gcr_tgl_q;
  cfg_t wr_data_q;

  pin_sync #(.WIDTH(3), .RST_VAL(3'b000)) u_sys_sync (
    .clk(sys_clk),
    .rst_n(resetn),
    .d({ack_q, wr_tgl_q, gcr_tgl_q}),
    .q(sys_s)
  );

  wire logic wr_evt = sys_s[1] ^ sys_p_q[1];
  wire logic gcr_evt = sys_s[0] ^ sys_p_q[0];

  conv_core #(.CONV_TICKS(CONV_TICKS)) u_core (
    .clk(sys_clk),
    .rst_n(resetn),
    .cfg_wr(wr_evt),
    .cfg_wr_data(wr_data_q),
    .gc_reset(gcr_evt),
    .analog_code(analog_code),
    .analog_pwr_en(analog_pwr_en),
    .gain_setting(gain_setting),
    .result(result),
    .cfg_rd(cfg_rd)
  );

  // A new snapshot is offered only once the last one was acknowledged
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sys_p_q <= 3'b000;
      pub_req_q <= 1'b0;
      pub_q <= '0;
    end else begin
      sys_p_q <= sys_s;
      if (pub_req_q == sys_s[2]) begin
        pub_q <= '{result: result, cfg: cfg_rd};
        pub_req_q <= ~pub_req_q;
      end
    end
  end

  // ==========================================================================
  // Link side (link_clk): pin conditioning and crossing
  logic [2:0] link_s;
  logic scl_p_q;
  logic sda_p_q;
  status_word_t shadow_q;

  pin_sync #(.WIDTH(3), .RST_VAL(3'b110)) u_link_sync (
    .clk(link_clk),
    .rst_n(resetn),
    .d({scl_i, sda_i, pub_req_q}),
    .q(link_s)
  );

  wire logic scl_s = link_s[2];
  wire logic sda_s = link_s[1];
  wire logic scl_rise = scl_s && !scl_p_q;
  wire logic scl_fall = !scl_s && scl_p_q;
  wire logic start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire logic stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      ack_q <= 1'b0;
      shadow_q <= '0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (link_s[0] != ack_q) begin
        shadow_q <= pub_q;
        ack_q <= link_s[0];
      end
    end
  end

  // ==========================================================================
  // Link side: byte engine
  bus_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] tx_sh_q;
  logic [1:0] byte_idx_q;
  logic [1:0] rd_idx_q;
  logic gc_q;
  logic go_tx_q;
  logic go_rx_q;
  logic hs_q;
  logic sda_oe_n_q;
  logic sda_o_q;
  status_word_t snap_q;

  function automatic logic [7:0] rd_byte(input logic [1:0] idx,
                                         input status_word_t w);
    logic [7:0] b;
    b = `FILL_BYTE;
    unique case (idx)
      2'h0: b = w.result[15:8];
      2'h1: b = w.result[7:0];
      2'h2: b = w.cfg;
      2'h3: b = `FILL_BYTE;
    endcase
    return b;
  endfunction

  wire logic byte_end = scl_fall && (bit_cnt_q == 4'h8);
  wire logic first = (byte_idx_q == 2'h0);
  wire logic second = (byte_idx_q == 2'h1);
  wire logic addr_hit = (rx_sh_q[7:1] == DEV_ADDR);
  wire logic is_gc = (rx_sh_q == `GC_ADDR);
  wire logic is_hs = (rx_sh_q[7:3] == `HS_CODE);
  wire logic gc_data_ok = (rx_sh_q == `GC_RESET_CODE) ||
    (rx_sh_q == `GC_OTHER_CODE);
  wire logic ack_now = first ? (addr_hit || is_gc || is_hs) :
    (second && (gc_q ? gc_data_ok : 1'b1));
  wire logic [1:0] rd_next = (rd_idx_q == 2'h3) ? 2'h3
    : rd_idx_q + 2'h1;
  wire logic [7:0] tx_first = rd_byte(2'h0, snap_q);
  wire logic [7:0] tx_next = rd_byte(rd_next, snap_q);

  // Drive changes only follow a falling clock, so data is stable while high
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= BUS_IDLE;
      bit_cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
      tx_sh_q <= 8'hff;
      byte_idx_q <= 2'h0;
      rd_idx_q <= 2'h0;
      gc_q <= 1'b0;
      go_tx_q <= 1'b0;
      go_rx_q <= 1'b0;
      hs_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      snap_q <= '0;
      wr_tgl_q <= 1'b0;
      gcr_tgl_q <= 1'b0;
      wr_data_q <= '0;
    end else if (start_c) begin
      state_q <= RX_BYTE;
      bit_cnt_q <= 4'h0;
      byte_idx_q <= 2'h0;
      gc_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_c) begin
      state_q <= BUS_IDLE;
      sda_oe_n_q <= 1'b1;
      hs_q <= 1'b0;
    end else begin
      unique case (state_q)
        BUS_IDLE, SKIP: begin
        end
        RX_BYTE: begin
          if (scl_rise) begin
            rx_sh_q <= {rx_sh_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_end) begin
            bit_cnt_q <= 4'h0;
            state_q <= ack_now ? ACK_OUT : SKIP;
            sda_oe_n_q <= !ack_now;
            go_tx_q <= first && addr_hit && rx_sh_q[0];
            go_rx_q <= first && ((addr_hit && !rx_sh_q[0]) || is_gc);
            if (!byte_idx_q[1]) begin
              byte_idx_q <= byte_idx_q + 2'h1;
            end
            if (first) begin
              gc_q <= is_gc;
              snap_q <= shadow_q;
              rd_idx_q <= 2'h0;
              if (is_hs) begin
                hs_q <= 1'b1;
              end
            end
            if (second && !gc_q) begin
              wr_data_q <= cfg_t'(rx_sh_q);
              wr_tgl_q <= ~wr_tgl_q;
            end
            if (second && gc_q && rx_sh_q == `GC_RESET_CODE) begin
              gcr_tgl_q <= ~gcr_tgl_q;
            end
          end
        end
        ACK_OUT: begin
          if (scl_fall) begin
            if (go_tx_q) begin
              state_q <= TX_BYTE;
              sda_oe_n_q <= tx_first[7];
              tx_sh_q <= {tx_first[6:0], 1'b1};
            end else begin
              state_q <= go_rx_q ? RX_BYTE : SKIP;
              sda_oe_n_q <= 1'b1;
            end
          end
        end
        TX_BYTE: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_end) begin
            bit_cnt_q <= 4'h0;
            state_q <= ACK_IN;
            sda_oe_n_q <= 1'b1;
          end else if (scl_fall) begin
            sda_oe_n_q <= tx_sh_q[7];
            tx_sh_q <= {tx_sh_q[6:0], 1'b1};
          end
        end
        ACK_IN: begin
          if (scl_rise && sda_s) begin
            state_q <= SKIP;
          end else if (scl_fall) begin
            rd_idx_q <= rd_next;
            state_q <= TX_BYTE;
            sda_oe_n_q <= tx_next[7];
            tx_sh_q <= {tx_next[6:0], 1'b1};
          end
        end
      endcase
    end
  end

  // The data line is only ever pulled low; the clock line is never driven
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign sda_o = sda_o_q;
  assign sda_oe_n = sda_oe_n_q;
  assign high_speed_bus_mode = hs_q;

  // ==========================================================================
  // Checks
  property p_ack_drive;
    @(posedge link_clk) disable iff (!resetn)
    state_q == RX_BYTE && byte_end && ack_now && !start_c && !stop_c
      |=> !sda_oe_n_q && state_q == ACK_OUT;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("accepted byte not acknowledged");

  property p_stop_idle;
    @(posedge link_clk) disable iff (!resetn)
    stop_c && !start_c |=> state_q == BUS_IDLE && sda_oe_n_q && !hs_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return to idle");

  property p_drive_low_clk;
    @(posedge link_clk) disable iff (!resetn)
    $fell(sda_oe_n_q) |-> !scl_s;
  endproperty
  a_drive_low_clk: assert property (p_drive_low_clk)
    else $error("data driven while clock high");

  property p_nack_foreign;
    @(posedge link_clk) disable iff (!resetn)
    state_q == RX_BYTE && byte_end && first && !addr_hit && !is_gc
      && !is_hs && !start_c && !stop_c |=> state_q == SKIP
      ##1 sda_oe_n_q;
  endproperty
  a_nack_foreign: assert property (p_nack_foreign)
    else $error("foreign address acknowledged");

endmodule

`default_nettype wire

// [verification/bus_master_model.sv]
/*
  Two-wire bus master model: start, stop, byte write and byte read.
  Assumes the device only pulls the data line low and both lines have
  pull-ups; every step lasts one quarter of a bit.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_master_model #(
  parameter int QTR = 50
) (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda_o,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda
);
  logic rel = 1'b1;

  // ====================
  // Wired-and data line
  initial scl = 1'b1;
  assign sda = rel & (sda_oe_n | sda_o);

  // ====================
  // Bus steps
  task automatic put(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    rel <= d;
    repeat (QTR - 1) @(posedge clk);
  endtask

  // Data moves a quarter after the fall, never while the clock is high
  task automatic bit_io(input logic d, output logic s);
    put(1'b0, rel);
    put(1'b0, d);
    put(1'b1, d);
    s = sda;
    put(1'b1, d);
  endtask

  task automatic start();
    put(1'b0, rel);
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
  endtask

  task automatic stop();
    put(1'b0, rel);
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(!ack, s);
  endtask
endmodule

`default_nettype wire

// [verification/tb.sv]
/*
  Self-checking bench for the converter's digital side.
  Assumes the master model drives the bus and the device answers the
  first factory address; conversions are shortened to 8 ticks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"

module tb;
  localparam int TICKS = 8;
  localparam int CONV = TICKS * 727;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic signed [15:0] analog_code = 16'sh012c;
  logic scl, sda, sda_o, sda_oe_n, pwr_en, high_speed_bus_mode;
  logic [1:0] gain;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  // ====================
  // Clocks, device and master
  always #2.5 sys_clk = ~sys_clk;
  always #24 link_clk = ~link_clk;

  adc_i2c_slave #(.ADDR_SEL(1'b0), .CONV_TICKS(TICKS)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .analog_code(analog_code), .analog_pwr_en(pwr_en),
    .gain_setting(gain), .high_speed_bus_mode(high_speed_bus_mode));

  bus_master_model #(.QTR(50)) m_u (.clk(sys_clk), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

  // ====================
  // Shared helpers
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic exp);
    logic a;
    m_u.wr_byte(b, a);
    chk("ack", 16'(exp), 16'(a));
  endtask

  task automatic wr_cfg(input logic [7:0] c);
    m_u.start();
    send({`DEV_ADDR_A, 1'b0}, 1'b1);
    send(c, 1'b1);
    m_u.stop();
  endtask

  task automatic rd_all(input logic [15:0] res, input logic [7:0] cfg);
    logic [7:0] b [4];
    m_u.start();
    send({`DEV_ADDR_A, 1'b1}, 1'b1);
    for (int i = 0; i < 4; i++) begin
      m_u.rd_byte(i < 3, b[i]);
    end
    m_u.stop();
    chk("result", res, {b[0], b[1]});
    chk("config", 16'(cfg), 16'(b[2]));
    chk("fill", 16'(`FILL_BYTE), 16'(b[3]));
  endtask

  // Bounded wait; a level that never arrives is reported, not hung on
  task automatic wait_pwr(input logic v, input int max);
    int n = 0;
    while (pwr_en !== v && n < max) begin
      @(posedge sys_clk);
      n++;
    end
    chk("pwr_en", 16'(v), 16'(pwr_en));
  endtask

  // ====================
  // Scenarios
  task automatic s_reset_read();
    chk("gain", 16'h0000, 16'(gain));
    chk("pwr_en", 16'h0001, 16'(pwr_en));
    rd_all(16'h0000, `CFG_DEFAULT);
  endtask

  task automatic s_address();
    m_u.start();
    send({`DEV_ADDR_B, 1'b0}, 1'b0);
    m_u.start();
    send({`DEV_ADDR_A, 1'b0}, 1'b1);
    send(`CFG_DEFAULT, 1'b1);
    m_u.stop();
    m_u.start();
    send(8'h09, 1'b1);
    chk("high_speed", 16'h0001, 16'(high_speed_bus_mode));
    m_u.stop();
    // The stop needs up to five link clocks to pass the pin filter
    repeat (20) @(posedge sys_clk);
    chk("high_speed", 16'h0000, 16'(high_speed_bus_mode));
  endtask

  task automatic s_gain_sat();
    m_u.start();
    send({`DEV_ADDR_A, 1'b0}, 1'b1);
    send(8'h03, 1'b1);
    send(8'h10, 1'b0);
    m_u.stop();
    chk("gain", 16'h0003, 16'(gain));
    repeat (CONV + 200) @(posedge sys_clk);
    rd_all(16'h07ff, 8'h83);
  endtask

  task automatic s_single();
    int n = 0;
    @(posedge sys_clk);
    // Minus 1000 at gain x2 stays inside the range, so scaling is seen
    analog_code <= 16'shfc18;
    wr_cfg(8'h10);
    wait_pwr(1'b0, CONV + 200);
    wr_cfg(8'h91);
    chk("pwr_en", 16'h0001, 16'(pwr_en));
    wr_cfg(8'h91);
    wait_pwr(1'b0, CONV);
    repeat (2000) begin
      @(posedge sys_clk);
      if (pwr_en !== 1'b0) n++;
    end
    chk("idle", 16'h0000, 16'(n));
    rd_all(16'hf830, 8'h11);
  endtask

  task automatic s_gc();
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wr_cfg(8'h92);
      m_u.start();
      send(`GC_ADDR, 1'b1);
      send(8'h04 + 8'(i), i != 1);
      m_u.stop();
    end
    chk("gain", 16'h0000, 16'(gain));
    rd_all(16'h0000, `CFG_DEFAULT);
  endtask

  // ====================
  // Verdict and run control
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 105000) begin
      bad_count++;
      $display("[ERR] cycles expected below 105000 seen %0d", cycles);
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (200) @(posedge sys_clk);
    s_reset_read();
    s_address();
    s_gain_sat();
    s_single();
    s_gc();
    conclude();
  end
endmodule

`default_nettype wire
